// >>> rtl/asrp_defines.svh
// timing and field constants of the serial result port
`ifndef ASRP_DEFINES_SVH
`define ASRP_DEFINES_SVH
`define ASRP_RESULT_BITS 16
`define ASRP_FLOAT_EDGE 17
`define ASRP_CNT_BITS 5
`define ASRP_FIFO_DEPTH 32
`endif

// >>> rtl/asrp_fifo.sv
// result word fifo with valid and ready on both sides
`timescale 1ns/1ps
module asrp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) wr_ptr <= wr_ptr + 1'b1;
            if (do_rd) rd_ptr <= rd_ptr + 1'b1;
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (do_wr) mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule : asrp_fifo

// >>> rtl/asrp_pkg.sv
// types of the serial result port
package asrp_pkg;
    typedef enum logic [1:0] {
        ASRP_IDLE = 2'b00,
        ASRP_SHIFT = 2'b01,
        ASRP_DONE = 2'b11
    } asrp_state_t;
endpackage : asrp_pkg

// >>> rtl/asrp_port.sv
// serial result port: shifts converter results out to a host
`timescale 1ns/1ps
`include "asrp_defines.svh"
module asrp_port
#(
    parameter int RESULT_BITS = `ASRP_RESULT_BITS,
    parameter int FIFO_DEPTH = `ASRP_FIFO_DEPTH
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic SELECT_N,
    input wire logic SHIFT_CLK,
    input wire logic [RESULT_BITS-1:0] RESULT_DATA,
    input wire logic RESULT_VALID,
    output logic RESULT_READY,
    output logic SERIAL_RESULT_OUT,
    output logic SERIAL_RESULT_OE_N
);
    import asrp_pkg::*;
    // pins cross from the host's domain, so two flops first
    logic [1:0] sel_sync;
    logic [1:0] sck_sync;
    logic sel_q;
    logic sck_q;
    asrp_state_t state;
    asrp_state_t next_state;
    logic [RESULT_BITS-1:0] shreg;
    logic [`ASRP_CNT_BITS-1:0] rise_cnt;
    logic [RESULT_BITS-1:0] fifo_data;
    logic fifo_valid;
    wire sel_now = sel_sync[1];
    wire sck_now = sck_sync[1];
    wire sel_fall = sel_q && !sel_now;
    wire sck_rise = !sck_q && sck_now;
    wire last_rise = sck_rise && rise_cnt == `ASRP_CNT_BITS'(`ASRP_FLOAT_EDGE - 1);
    // a frame with no word ready shifts zeros rather than stale data
    wire load = sel_fall && state == ASRP_IDLE;
    wire pop = load && fifo_valid;
    wire in_shift = state == ASRP_SHIFT;
    wire load_msb = fifo_valid && fifo_data[RESULT_BITS-1];
    wire shreg_moves = load || (in_shift && sck_rise);

    asrp_fifo #(.WIDTH(RESULT_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .CORE_CLK(CORE_CLK),
        .RST_N(RST_N),
        .in_data(RESULT_DATA),
        .in_valid(RESULT_VALID),
        .in_ready(RESULT_READY),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(pop)
    );

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_sync <= 2'h3;
            // idle-high shift clock: no false rise after reset
            sck_sync <= 2'h3;
            sel_q <= 1'b1;
            sck_q <= 1'b1;
        end else begin
            sel_sync <= {sel_sync[0], SELECT_N};
            sck_sync <= {sck_sync[0], SHIFT_CLK};
            sel_q <= sel_now;
            sck_q <= sck_now;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ASRP_IDLE: if (sel_fall) next_state = ASRP_SHIFT;
            ASRP_SHIFT: begin
                if (sel_now) next_state = ASRP_IDLE;
                else if (last_rise) next_state = ASRP_DONE;
            end
            ASRP_DONE: if (sel_now) next_state = ASRP_IDLE;
            default: next_state = ASRP_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ASRP_IDLE;
            shreg <= '0;
            rise_cnt <= '0;
        end else begin
            state <= next_state;
            if (load) begin
                shreg <= fifo_valid ? fifo_data : '0;
                rise_cnt <= '0;
            end else if (state == ASRP_SHIFT && sck_rise) begin
                shreg <= {shreg[RESULT_BITS-2:0], 1'b0};
                rise_cnt <= rise_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            SERIAL_RESULT_OUT <= 1'b0;
            SERIAL_RESULT_OE_N <= 1'b1;
        end else begin
            SERIAL_RESULT_OUT <= shreg[RESULT_BITS-1];
            SERIAL_RESULT_OE_N <= !(state == ASRP_SHIFT && !sel_now);
        end
    end

    sequence s_frame_start;
        sel_fall && state == ASRP_IDLE;
    endsequence
    property p_drive_on_select;
        @(posedge CORE_CLK) disable iff (!RST_N)
        s_frame_start ##1 !sel_now |=> !SERIAL_RESULT_OE_N;
    endproperty
    a_drive_on_select: assert property (p_drive_on_select)
        else $error("output not driven after select fell");
    property p_float_when_high;
        @(posedge CORE_CLK) disable iff (!RST_N)
        sel_now |=> SERIAL_RESULT_OE_N;
    endproperty
    a_float_when_high: assert property (p_float_when_high)
        else $error("output driven while select high");
    property p_float_after_17;
        @(posedge CORE_CLK) disable iff (!RST_N)
        state == ASRP_SHIFT && last_rise && !sel_now |=> ##1 SERIAL_RESULT_OE_N;
    endproperty
    a_float_after_17: assert property (p_float_after_17)
        else $error("output still driven after last rise");
    property p_msb_first;
        @(posedge CORE_CLK) disable iff (!RST_N)
        load |=> ##1 SERIAL_RESULT_OUT == $past(load_msb, 2);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first bit is not the msb");
    property p_stable_no_rise;
        @(posedge CORE_CLK) disable iff (!RST_N)
        state == ASRP_SHIFT && !sck_rise && !sel_fall |=> $stable(shreg);
    endproperty
    a_stable_no_rise: assert property (p_stable_no_rise)
        else $error("data moved without a shift-clock rise");
    property p_shift_on_rise;
        @(posedge CORE_CLK) disable iff (!RST_N)
        state == ASRP_SHIFT && sck_rise |=> rise_cnt == $past(rise_cnt) + 1'b1;
    endproperty
    a_shift_on_rise: assert property (p_shift_on_rise)
        else $error("rise not counted");
    property p_keep_driving;
        @(posedge CORE_CLK) disable iff (!RST_N)
        state == ASRP_SHIFT && !sel_now && rise_cnt < 5'h10 |=> state != ASRP_DONE;
    endproperty
    a_keep_driving: assert property (p_keep_driving)
        else $error("frame ended before lsb");
    property p_pop_once;
        @(posedge CORE_CLK) disable iff (!RST_N)
        pop |=> !pop && in_shift;
    endproperty
    a_pop_once: assert property (p_pop_once)
        else $error("two words taken for one frame");
    property p_load_word;
        @(posedge CORE_CLK) disable iff (!RST_N)
        load && fifo_valid |=> shreg == $past(fifo_data);
    endproperty
    a_load_word: assert property (p_load_word)
        else $error("frame did not take the waiting word");
    property p_empty_zero;
        @(posedge CORE_CLK) disable iff (!RST_N)
        load && !fifo_valid |=> shreg == '0;
    endproperty
    a_empty_zero: assert property (p_empty_zero)
        else $error("empty frame did not load zeros");
    property p_shift_moves_bits;
        @(posedge CORE_CLK) disable iff (!RST_N)
        in_shift && sck_rise |=> shreg == ($past(shreg) << 1);
    endproperty
    a_shift_moves_bits: assert property (p_shift_moves_bits)
        else $error("rise did not move the next bit up");
    property p_out_moves_on_rise;
        @(posedge CORE_CLK) disable iff (!RST_N)
        $changed(SERIAL_RESULT_OUT) |-> $past(shreg_moves, 2);
    endproperty
    a_out_moves_on_rise: assert property (p_out_moves_on_rise)
        else $error("output bit moved without a shift-clock rise");
    property p_drive_only_in_frame;
        @(posedge CORE_CLK) disable iff (!RST_N)
        !SERIAL_RESULT_OE_N |-> $past(in_shift) && !$past(sel_now);
    endproperty
    a_drive_only_in_frame: assert property (p_drive_only_in_frame)
        else $error("output driven outside a frame");
    property p_idle_on_select_rise;
        @(posedge CORE_CLK) disable iff (!RST_N)
        $rose(sel_now) |=> state == ASRP_IDLE;
    endproperty
    a_idle_on_select_rise: assert property (p_idle_on_select_rise)
        else $error("frame kept after select rose");
    property p_count_bound;
        @(posedge CORE_CLK) disable iff (!RST_N)
        rise_cnt <= `ASRP_CNT_BITS'(`ASRP_FLOAT_EDGE);
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("rise count passed the float edge");
    property p_done_floats;
        @(posedge CORE_CLK) disable iff (!RST_N)
        state == ASRP_DONE |=> SERIAL_RESULT_OE_N;
    endproperty
    a_done_floats: assert property (p_done_floats)
        else $error("output driven after the frame ended");
    property p_extra_rises_ignored;
        @(posedge CORE_CLK) disable iff (!RST_N)
        !in_shift && !load |=> $stable(rise_cnt);
    endproperty
    a_extra_rises_ignored: assert property (p_extra_rises_ignored)
        else $error("rise counted outside a frame");
endmodule : asrp_port

// >>> test/asrp_host.sv
// host model: drives frame select and shift clock, captures result bits
`timescale 1ns/1ps
module asrp_host (
    input wire logic CORE_CLK,
    output logic SELECT_N,
    output logic SHIFT_CLK,
    input wire logic SERIAL_RESULT_OUT,
    input wire logic SERIAL_RESULT_OE_N
);
    // floating pin shows the inverse so a late enable never passes as data
    wire logic bit_line = SERIAL_RESULT_OE_N ? ~SERIAL_RESULT_OUT : SERIAL_RESULT_OUT;
    initial begin
        SELECT_N = 1'b1;
        SHIFT_CLK = 1'b1;
    end
    task automatic wait_core(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask : wait_core
    // clock idles high; half period of 8 core cycles gives 80 ns
    task automatic frame(input int n_rise, output logic [15:0] word, output logic oe_n);
        word = 16'h0000;
        SELECT_N = 1'b0;
        wait_core(8);
        oe_n = SERIAL_RESULT_OE_N;
        for (int i = 0; i < n_rise; i++) begin
            SHIFT_CLK = 1'b0;
            if (i < 16) word = {word[14:0], bit_line};
            wait_core(8);
            SHIFT_CLK = 1'b1;
            wait_core(8);
        end
    endtask : frame
    task automatic release_sel();
        SELECT_N = 1'b1;
        wait_core(8);
    endtask : release_sel
endmodule : asrp_host

// >>> test/asrp_port_tb.sv
// self-checking bench of the serial result port with a host model
`timescale 1ns/1ps
module asrp_port_tb;
    logic CORE_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [15:0] RESULT_DATA = 16'h0000;
    logic RESULT_VALID = 1'b0;
    wire logic RESULT_READY;
    wire logic SELECT_N;
    wire logic SHIFT_CLK;
    wire logic SERIAL_RESULT_OUT;
    wire logic SERIAL_RESULT_OE_N;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [15:0] sent[$];
    always #5 CORE_CLK = ~CORE_CLK;
    asrp_port asrp_port_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .SELECT_N(SELECT_N),
        .SHIFT_CLK(SHIFT_CLK), .RESULT_DATA(RESULT_DATA), .RESULT_VALID(RESULT_VALID),
        .RESULT_READY(RESULT_READY), .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT),
        .SERIAL_RESULT_OE_N(SERIAL_RESULT_OE_N));
    asrp_host asrp_host_i (.CORE_CLK(CORE_CLK), .SELECT_N(SELECT_N), .SHIFT_CLK(SHIFT_CLK),
        .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT), .SERIAL_RESULT_OE_N(SERIAL_RESULT_OE_N));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    // a hung handshake would stall forever without this ceiling
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    // host stalls while the fifo fills until it refuses
    task automatic fill_fifo();
        logic [15:0] w;
        int n;
        n = 0;
        RESULT_VALID = 1'b1;
        for (int i = 0; i < 40; i++) begin
            w = 16'h8001 ^ (16'(n) * 16'h1357);
            RESULT_DATA = w;
            @(posedge CORE_CLK);
            if (RESULT_READY === 1'b1) begin
                sent.push_back(w);
                n++;
            end
            #1;
        end
        RESULT_VALID = 1'b0;
        check("pushed words", 16'h0020, 16'(n));
    endtask : fill_fifo
    task automatic read_frame(input int n_rise);
        logic [15:0] exp;
        logic [15:0] got;
        logic oe_n;
        exp = (sent.size() > 0) ? sent.pop_front() : 16'h0000;
        check("idle enable", 16'h0001, 16'(SERIAL_RESULT_OE_N));
        asrp_host_i.frame(n_rise, got, oe_n);
        check("enable after select", 16'h0000, 16'(oe_n));
        check("result word", exp, got);
        check("enable after last rise", 16'(n_rise > 16), 16'(SERIAL_RESULT_OE_N));
        asrp_host_i.release_sel();
        check("enable after select rise", 16'h0001, 16'(SERIAL_RESULT_OE_N));
    endtask : read_frame
    initial begin
        repeat (5) @(posedge CORE_CLK);
        #1;
        RST_N = 1'b1;
        fill_fifo();
        for (int k = 0; k < 34; k++)
            read_frame(16 + (k % 2));
        end_of_test();
    end
endmodule : asrp_port_tb
